/* File: rtl/esc_pkg.sv */
// Purpose: Constants for the EDAC SRAM host controller
// Assumes: 100 MHz clock, SRAM pins sampled synchronously
// Notes: Times in ps, cycle counts derived from them
package esc_pkg;
	localparam int ADDR_W        = 19;
	localparam int DATA_W        = 32;
	localparam int TMR_W         = 4;
	localparam int CLK_PERIOD_PS = 10000;

	localparam int T_AVQV_PS = 20000;
	localparam int T_GLMV_PS = 8600;
	localparam int T_GHQZ_PS = 5000;
	localparam int T_AVWL_PS = 3600;
	localparam int T_DVWH_PS = 8200;
	localparam int T_WHAX_PS = 2300;

	function automatic int cyc_up(input int ps);
		int c;
		c = (ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
		return (c < 1) ? 1 : c;
	endfunction

	localparam int T_AVQV_CYC = cyc_up(T_AVQV_PS);
	localparam int T_GLMV_CYC = cyc_up(T_GLMV_PS);
	localparam int T_GHQZ_CYC = cyc_up(T_GHQZ_PS);
	localparam int T_AVWL_CYC = cyc_up(T_AVWL_PS);
	localparam int T_DVWH_CYC = cyc_up(T_DVWH_PS);
	localparam int T_WHAX_CYC = cyc_up(T_WHAX_PS);

	localparam logic [TMR_W-1:0] RD_ACC_LEN = TMR_W'(T_AVQV_CYC - 1);
	localparam logic [TMR_W-1:0] OE_RD_LEN  = TMR_W'(T_GLMV_CYC - 1);
	localparam logic [TMR_W-1:0] HIZ_LEN    = TMR_W'(T_GHQZ_CYC - 1);
	localparam logic [TMR_W-1:0] WR_SET_LEN = TMR_W'(T_AVWL_CYC - 1);
	localparam logic [TMR_W-1:0] WR_PUL_LEN = TMR_W'(T_DVWH_CYC - 1);
	localparam logic [TMR_W-1:0] WR_HLD_LEN = TMR_W'(T_WHAX_CYC - 1);
	localparam logic [TMR_W-1:0] STEP_LEN   = 4'h0;

	typedef enum logic [9:0] {
		S_IDLE   = 10'h001,
		S_RD     = 10'h002,
		S_WR_SET = 10'h004,
		S_WR_PUL = 10'h008,
		S_WR_HLD = 10'h010,
		S_CL_DES = 10'h020,
		S_CL_OEH = 10'h040,
		S_CL_ADR = 10'h080,
		S_CL_SEL = 10'h100,
		S_CL_RD  = 10'h200
	} esc_state_t;
endpackage

/* File: rtl/esc_sram_host.sv */
// Purpose: Host controller for an asynchronous EDAC SRAM
// Assumes: Pin inputs synchronous to clk, flag pulled low off-chip
// Notes: Idles in scrub standby; clears a raised error flag itself
`timescale 1ns/100ps
module esc_sram_host #(
	parameter int       ADDR_W     = esc_pkg::ADDR_W,
	parameter int       DATA_W     = esc_pkg::DATA_W,
	parameter bit       CLR_BY_CSA = 1'b0
) (
	// Clock and reset
	input  wire logic              clk,
	input  wire logic              rst_n,
	// User request
	input  wire logic              reqValid,
	input  wire logic              reqWrite,
	input  wire logic [ADDR_W-1:0] reqAddr,
	input  wire logic [DATA_W-1:0] reqWdata,
	output      logic              reqReady,
	// User response
	output      logic              rspValid,
	output      logic [DATA_W-1:0] rspData,
	output      logic              rspError,
	output      logic              clearBusy,
	// SRAM control pins
	output      logic              chipSelectAN,
	output      logic              chipSelectB,
	output      logic              writeStrobeN,
	output      logic              outputDriveN,
	output      logic [ADDR_W-1:0] sramAddr,
	// SRAM data bus
	input  wire logic [DATA_W-1:0] dqIn,
	output      logic [DATA_W-1:0] dqOut,
	output      logic              dqOe,
	// SRAM error flag
	input  wire logic              errorFlagIn,
	output      logic              errorFlagOut,
	output      logic              errorFlagOe
);
	esc_pkg::esc_state_t state_reg;
	logic [ADDR_W-1:0]   lastGood_reg;
	logic                tStart_reg;
	logic [esc_pkg::TMR_W-1:0] tLen_reg;

	esc_wait_if wt ();

	assign wt.start = tStart_reg;
	assign wt.len   = tLen_reg;

	esc_wait_timer u_timer (
		.clk   (clk),
		.rst_n (rst_n),
		.w     (wt.tmr)
	);

	// Pin sequencing
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_reg    <= esc_pkg::S_IDLE;
			chipSelectAN <= 1'b1;
			chipSelectB  <= 1'b0;
			writeStrobeN <= 1'b1;
			outputDriveN <= 1'b1;
			sramAddr     <= '0;
			dqOe         <= 1'b0;
			reqReady     <= 1'b0;
			clearBusy    <= 1'b0;
			tStart_reg   <= 1'b0;
			tLen_reg     <= esc_pkg::STEP_LEN;
		end else begin
			tStart_reg <= 1'b0;
			unique case (state_reg)
			esc_pkg::S_IDLE: begin
				// Idle in scrub standby, bus floating
				chipSelectAN <= 1'b0;
				chipSelectB  <= 1'b0;
				writeStrobeN <= 1'b1;
				outputDriveN <= 1'b1;
				dqOe         <= 1'b0;
				clearBusy    <= 1'b0;
				reqReady     <= 1'b1;
				if (reqValid && reqReady) begin
					sramAddr    <= reqAddr;
					reqReady    <= 1'b0;
					chipSelectB <= 1'b1;
					tStart_reg  <= 1'b1;
					if (reqWrite) begin
						// Drive high during write, no write-through
						dqOe      <= 1'b1;
						tLen_reg  <= esc_pkg::WR_SET_LEN;
						state_reg <= esc_pkg::S_WR_SET;
					end else begin
						// Selection, address and drive move together
						outputDriveN <= 1'b0;
						tLen_reg     <= esc_pkg::RD_ACC_LEN;
						state_reg    <= esc_pkg::S_RD;
					end
				end
			end
			esc_pkg::S_RD: begin
				if (wt.done) begin
					tStart_reg <= 1'b1;
					if (errorFlagIn) begin
						// Deselect while drive stays low
						if (CLR_BY_CSA) begin
							chipSelectAN <= 1'b1;
						end else begin
							chipSelectB <= 1'b0;
						end
						clearBusy <= 1'b1;
						tLen_reg  <= esc_pkg::STEP_LEN;
						state_reg <= esc_pkg::S_CL_DES;
					end else begin
						outputDriveN <= 1'b1;
						chipSelectB  <= 1'b0;
						state_reg    <= esc_pkg::S_IDLE;
					end
				end
			end
			esc_pkg::S_CL_DES: begin
				if (wt.done) begin
					outputDriveN <= 1'b1;
					tStart_reg   <= 1'b1;
					tLen_reg     <= esc_pkg::HIZ_LEN;
					state_reg    <= esc_pkg::S_CL_OEH;
				end
			end
			esc_pkg::S_CL_OEH: begin
				// Stay deselected until flag reads low
				if (wt.done && !errorFlagIn) begin
					sramAddr   <= lastGood_reg;
					tStart_reg <= 1'b1;
					tLen_reg   <= esc_pkg::STEP_LEN;
					state_reg  <= esc_pkg::S_CL_ADR;
				end
			end
			esc_pkg::S_CL_ADR: begin
				if (wt.done) begin
					// Reselect with drive still high
					chipSelectAN <= 1'b0;
					chipSelectB  <= 1'b1;
					tStart_reg   <= 1'b1;
					tLen_reg     <= esc_pkg::RD_ACC_LEN;
					state_reg    <= esc_pkg::S_CL_SEL;
				end
			end
			esc_pkg::S_CL_SEL: begin
				if (wt.done) begin
					outputDriveN <= 1'b0;
					tStart_reg   <= 1'b1;
					tLen_reg     <= esc_pkg::OE_RD_LEN;
					state_reg    <= esc_pkg::S_CL_RD;
				end
			end
			esc_pkg::S_CL_RD: begin
				if (wt.done) begin
					outputDriveN <= 1'b1;
					chipSelectB  <= 1'b0;
					state_reg    <= esc_pkg::S_IDLE;
				end
			end
			esc_pkg::S_WR_SET: begin
				if (wt.done) begin
					writeStrobeN <= 1'b0;
					tStart_reg   <= 1'b1;
					tLen_reg     <= esc_pkg::WR_PUL_LEN;
					state_reg    <= esc_pkg::S_WR_PUL;
				end
			end
			esc_pkg::S_WR_PUL: begin
				if (wt.done) begin
					writeStrobeN <= 1'b1;
					tStart_reg   <= 1'b1;
					tLen_reg     <= esc_pkg::WR_HLD_LEN;
					state_reg    <= esc_pkg::S_WR_HLD;
				end
			end
			esc_pkg::S_WR_HLD: begin
				if (wt.done) begin
					dqOe        <= 1'b0;
					chipSelectB <= 1'b0;
					state_reg   <= esc_pkg::S_IDLE;
				end
			end
			endcase
		end
	end

	// Write data, response and last clean address
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			dqOut        <= '0;
			rspValid     <= 1'b0;
			rspData      <= '0;
			rspError     <= 1'b0;
			lastGood_reg <= '0;
		end else begin
			rspValid <= 1'b0;
			if (state_reg == esc_pkg::S_IDLE && reqValid && reqReady) begin
				dqOut <= reqWdata;
			end
			if (state_reg == esc_pkg::S_RD && wt.done) begin
				rspValid <= 1'b1;
				rspData  <= dqIn;
				rspError <= errorFlagIn;
				if (!errorFlagIn) begin
					lastGood_reg <= sramAddr;
				end
			end
			if (state_reg == esc_pkg::S_WR_HLD && wt.done) begin
				rspValid     <= 1'b1;
				rspError     <= 1'b0;
				lastGood_reg <= sramAddr;
			end
		end
	end

	// Flag is never driven, so function select is never entered
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			errorFlagOut <= 1'b0;
			errorFlagOe  <= 1'b0;
		end else begin
			errorFlagOut <= 1'b0;
			errorFlagOe  <= 1'b0;
		end
	end
endmodule

/* File: rtl/esc_wait_if.sv */
// Purpose: Carries wait requests between controller and timer
// Assumes: Single clock domain
// Notes: start is a one-cycle pulse
`timescale 1ns/100ps
interface esc_wait_if;
	logic                     start;
	logic [esc_pkg::TMR_W-1:0] len;
	logic                     done;
	modport ctl (output start, output len, input done);
	modport tmr (input start, input len, output done);
endinterface

/* File: rtl/esc_wait_timer.sv */
// Purpose: Down counter that times each pin phase
// Assumes: len loaded with start, counted from next edge
// Notes: done is high once the count has run out
`timescale 1ns/100ps
module esc_wait_timer (
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	// Wait request
	esc_wait_if.tmr   w
);
	logic [esc_pkg::TMR_W-1:0] cnt_reg;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cnt_reg <= '0;
		end else if (w.start) begin
			cnt_reg <= w.len;
		end else if (cnt_reg != '0) begin
			cnt_reg <= cnt_reg - 1'b1;
		end
	end

	assign w.done = (cnt_reg == '0) && !w.start;
endmodule

/* File: tb/esc_host_assertions.sv */
// Purpose: Port-level checks on the EDAC SRAM host
// Assumes: One clock, synchronous active-low reset
// Notes: Bound to esc_sram_host from tb
`timescale 1ns/100ps
module esc_host_assertions #(
	parameter int ADDR_W = 19
) (
	// Clock and reset
	input wire logic              clk,
	input wire logic              rst_n,
	// User side
	input wire logic              reqValid,
	input wire logic              reqWrite,
	input wire logic              reqReady,
	input wire logic              rspValid,
	input wire logic              rspError,
	input wire logic              clearBusy,
	// SRAM side
	input wire logic              chipSelectAN,
	input wire logic              chipSelectB,
	input wire logic              writeStrobeN,
	input wire logic              outputDriveN,
	input wire logic [ADDR_W-1:0] sramAddr,
	input wire logic              dqOe,
	input wire logic              errorFlagOe
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence rdPhase;
		!chipSelectAN && chipSelectB && !outputDriveN;
	endsequence
	sequence rdTake;
		reqValid && reqReady && !reqWrite;
	endsequence
	sequence wrTake;
		reqValid && reqReady && reqWrite;
	endsequence
	a_read_strobe: assert property (rdPhase |-> writeStrobeN)
		else $error("write strobe low during read");
	a_bus_turn: assert property (dqOe |-> outputDriveN)
		else $error("host drives bus with output drive low");
	a_write_select: assert property (!writeStrobeN |->
		!chipSelectAN && chipSelectB && outputDriveN && dqOe)
		else $error("write strobe without selection");
	a_flag_released: assert property (!errorFlagOe)
		else $error("host drives error flag");
	a_clear_order: assert property ($rose(outputDriveN) |->
		chipSelectAN || !chipSelectB)
		else $error("output drive raised while selected");
	a_reselect_high: assert property (
		$rose(chipSelectB) && clearBusy |-> outputDriveN)
		else $error("reselect with output drive low");
	a_error_clear: assert property (rspValid && rspError |=> clearBusy)
		else $error("no clear after flagged read");
	a_addr_stable: assert property (
		(rdPhase ##1 rdPhase) |-> $stable(sramAddr))
		else $error("address moved during read");
	a_read_done: assert property (rdTake |-> ##[2:6] rspValid)
		else $error("read response late");
	a_write_done: assert property (wrTake |-> ##[4:8] rspValid)
		else $error("write response late");
endmodule

/* File: tb/esc_sram_model.sv */
// Purpose: Behavioural EDAC SRAM seen by the host
// Assumes: Pins sampled on clk; unwritten words flag an error
// Notes: Flag clears on a drive-controlled read of a good word
`timescale 1ns/100ps
module esc_sram_model (
	// Sampling clock
	input wire logic        clk,
	// Control pins
	input wire logic        chipSelectAN,
	input wire logic        chipSelectB,
	input wire logic        writeStrobeN,
	input wire logic        outputDriveN,
	input wire logic [18:0] sramAddr,
	// Data bus
	input wire logic [31:0] dqIn,
	output     logic [31:0] dqOut,
	output     logic        dqOe,
	// Error flag
	output     logic        flagOut,
	output     logic        flagOe
);
	logic [31:0] mem [0:524287];
	bit          wr  [0:524287];
	logic        flagSet_reg  = 1'b0;
	logic        odPrev_reg   = 1'b1;
	logic        selPrev_reg  = 1'b0;
	logic [18:0] addrPrev_reg = 19'h0;
	int          accCyc       = 0;
	int          oeCyc        = 0;
	wire         sel   = !chipSelectAN && chipSelectB;
	wire         rdSel = sel && writeStrobeN;
	// Word is garbled until address, select and drive times have run
	wire         dataOk = (accCyc >= esc_pkg::T_AVQV_CYC) &&
		(oeCyc >= esc_pkg::T_GLMV_CYC);
	wire  [31:0] memWord = wr[sramAddr] ? mem[sramAddr] : 32'h0;
	assign dqOe    = rdSel && !outputDriveN;
	assign dqOut   = dataOk ? memWord : ~memWord;
	assign flagOe  = !outputDriveN && (rdSel || flagSet_reg);
	// Old flag dropped in first cycle of a drive-controlled read
	assign flagOut = flagSet_reg &&
		!(rdSel && odPrev_reg && wr[sramAddr]);
	always @(posedge clk) begin
		odPrev_reg   <= outputDriveN;
		selPrev_reg  <= sel;
		addrPrev_reg <= sramAddr;
		if (sel != selPrev_reg || sramAddr != addrPrev_reg) begin
			accCyc <= 1;
		end else if (accCyc < 7) begin
			accCyc <= accCyc + 1;
		end
		if (outputDriveN) begin
			oeCyc <= 0;
		end else if (oeCyc < 7) begin
			oeCyc <= oeCyc + 1;
		end
		if (sel && !writeStrobeN) begin
			mem[sramAddr] <= dqIn;
			wr[sramAddr]  <= 1'b1;
		end
		if (rdSel && !outputDriveN) begin
			// Unwritten word sets the flag on any driven read
			if (!wr[sramAddr]) flagSet_reg <= 1'b1;
			else if (odPrev_reg) flagSet_reg <= 1'b0;
		end
	end
endmodule

/* File: tb/tb.sv */
// Purpose: Self-checking bench for esc_sram_host
// Assumes: Model answers on the sampling clock
// Notes: Unwritten read exercises the flag clear
`timescale 1ns/100ps
module tb;
	logic        clk = 1'b0, rst_n = 1'b0, reqValid = 1'b0, reqWrite = 1'b0;
	logic [18:0] reqAddr = 19'h0, sramAddr, seen;
	logic [31:0] reqWdata = 32'h0, rspData, dqIn, dqOut, mDq;
	logic [31:0] lastDq = 32'h0;
	logic        reqReady, rspValid, rspError, clearBusy, chipSelectAN;
	logic        chipSelectB, writeStrobeN, outputDriveN, dqOe, mDqOe;
	logic        errorFlagIn, errorFlagOut, errorFlagOe, mFlag, mFlagOe;
	logic        csaHigh = 1'b0;
	int          errTotal = 0, comparisons = 0;
	logic [18:0] adr [3] = '{19'h00000, 19'h7FFFF, 19'h01000};
	always #5 clk = ~clk;
	assign dqIn = dqOe ? dqOut : (mDqOe ? mDq : ~lastDq);
	assign errorFlagIn = mFlagOe ? mFlag : (errorFlagOe & errorFlagOut);
	always @(posedge clk) lastDq <= dqIn;
	esc_sram_host u_esc_sram_host (.clk(clk), .rst_n(rst_n),
		.reqValid(reqValid), .reqWrite(reqWrite), .reqAddr(reqAddr),
		.reqWdata(reqWdata), .reqReady(reqReady), .rspValid(rspValid),
		.rspData(rspData), .rspError(rspError), .clearBusy(clearBusy),
		.chipSelectAN(chipSelectAN), .chipSelectB(chipSelectB),
		.writeStrobeN(writeStrobeN), .outputDriveN(outputDriveN),
		.sramAddr(sramAddr), .dqIn(dqIn), .dqOut(dqOut), .dqOe(dqOe),
		.errorFlagIn(errorFlagIn), .errorFlagOut(errorFlagOut),
		.errorFlagOe(errorFlagOe));
	esc_sram_model u_esc_sram_model (.clk(clk), .chipSelectAN(chipSelectAN),
		.chipSelectB(chipSelectB), .writeStrobeN(writeStrobeN),
		.outputDriveN(outputDriveN), .sramAddr(sramAddr), .dqIn(dqIn),
		.dqOut(mDq), .dqOe(mDqOe), .flagOut(mFlag), .flagOe(mFlagOe));
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			errTotal++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic conclude;
		$display("comparisons %0d mismatches %0d", comparisons, errTotal);
		if (errTotal == 0 && comparisons > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	// One request, waits for its response
	task automatic xfer(input logic w, input logic [18:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		do @(posedge clk); while (reqReady !== 1'b1 && ++n < 200);
		reqValid <= 1'b1;
		reqWrite <= w;
		reqAddr  <= a;
		reqWdata <= d;
		@(posedge clk);
		reqValid <= 1'b0;
		n = 0;
		do @(posedge clk); while (rspValid !== 1'b1 && ++n < 50);
		check(32'(rspValid), 32'h1);
	endtask
	task automatic t_reset;
		repeat (2) @(posedge clk);
		check({chipSelectAN, chipSelectB, outputDriveN, dqOe}, 32'h2);
		check(32'(errorFlagIn), 32'h0);
		check({errorFlagOe, errorFlagOut}, 32'h0);
	endtask
	task automatic t_rw;
		foreach (adr[i]) begin
			xfer(1'b1, adr[i], {13'h0, adr[i]} ^ 32'hA5A55A5A);
			check(32'(rspError), 32'h0);
			xfer(1'b0, adr[i], 32'h0);
			check(rspData, {13'h0, adr[i]} ^ 32'hA5A55A5A);
			check(32'(rspError), 32'h0);
		end
	endtask
	task automatic t_err;
		int n;
		n = 0;
		seen = 19'h0;
		xfer(1'b0, 19'h2ABCD, 32'h0);
		check(32'(rspError), 32'h1);
		do begin
			@(posedge clk);
			if (clearBusy === 1'b1 && chipSelectB === 1'b1) seen = sramAddr;
			if (clearBusy === 1'b1 && chipSelectAN !== 1'b0) csaHigh = 1'b1;
		end while (reqReady !== 1'b1 && ++n < 200);
		check(32'(seen), 32'h01000);
		check(32'(csaHigh), 32'h0);
		check(32'(errorFlagIn), 32'h0);
		xfer(1'b0, 19'h01000, 32'h0);
		check(32'(rspError), 32'h0);
		check(rspData, 32'hA5A54A5A);
	endtask
	initial begin
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		t_reset;
		t_rw;
		t_err;
		conclude;
	end
	initial begin
		#20000;
		errTotal++;
		conclude;
	end
endmodule
bind esc_sram_host esc_host_assertions #(.ADDR_W(ADDR_W))
	u_esc_host_assertions (.clk(clk), .rst_n(rst_n), .reqValid(reqValid),
	.reqWrite(reqWrite), .reqReady(reqReady), .rspValid(rspValid),
	.rspError(rspError), .clearBusy(clearBusy),
	.chipSelectAN(chipSelectAN), .chipSelectB(chipSelectB),
	.writeStrobeN(writeStrobeN), .outputDriveN(outputDriveN),
	.sramAddr(sramAddr), .dqOe(dqOe), .errorFlagOe(errorFlagOe));
